// *** rtl/multiport_bank_access.sv ***
`timescale 1ns/1ps

module multiport_bank_access
  import multiport_bank_pkg::*;
(
  // APB slave.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Supply monitor and interrupt.
  input  wire logic        pfail,
  output logic             irq_req,
  output logic [3:0]       irq_level,
  // Master bus.
  input  wire logic        gbl_req,
  input  wire logic        gbl_write,
  input  wire logic [4:0]  gbl_bank,
  input  wire logic [23:0] gbl_addr,
  input  wire logic [15:0] gbl_wdata,
  input  wire logic        gbl_refresh,
  input  wire logic        master_pwr_ok,
  input  wire logic [15:0] lbus_din,
  output logic             gbl_done,
  output logic             mbus_done_p,
  output logic             mbus_done_n,
  output logic [15:0]      mem_rdata,
  output logic [15:0]      io_data,
  // Port source.
  input  wire logic        src_req,
  input  wire logic        src_write,
  input  wire logic        src_lock,
  input  wire logic [23:0] src_addr,
  input  wire logic [15:0] src_wdata,
  input  wire logic        src_wpar,
  output logic             src_done,
  output logic             src_perr,
  output logic             src_rpar,
  // Local DMA.
  input  wire logic        dma_req,
  input  wire logic        dma_write,
  input  wire logic [7:0]  dma_addr,
  input  wire logic [15:0] dma_wdata,
  output logic             dma_done,
  // Shared backplane path.
  output logic [23:0]      bp_ad,
  output logic             bp_data_phase
);

  // ---------------------------------------------------------------
  // Check-bit code
  // ---------------------------------------------------------------

  // Hamming positions 1..21 plus overall parity in bit 0.
  function automatic logic [21:0] ecc_enc(input logic [15:0] d);
    logic [21:0] cw;
    int j;
    cw = '0;
    j = 0;
    for (int p = 1; p < 22; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 5; k++) begin
      for (int p = 3; p < 22; p++) begin
        if (p[k] && ((p & (p - 1)) != 0)) cw[1 << k] ^= cw[p];
      end
    end
    cw[0] = ^cw[21:1];
    return cw;
  endfunction

  // Returns {uncorrectable, corrected, data}.
  function automatic logic [17:0] ecc_dec(input logic [21:0] cw_in);
    logic [21:0] cw;
    logic [4:0]  syn;
    logic [15:0] d;
    logic        ovr;
    logic        ue;
    int          j;
    cw = cw_in;
    syn = '0;
    d = '0;
    j = 0;
    for (int p = 1; p < 22; p++) begin
      for (int k = 0; k < 5; k++) begin
        if (p[k]) syn[k] ^= cw[p];
      end
    end
    ovr = ^cw;
    ue = ((syn != 5'h00) && !ovr) || (ovr && (syn > 5'h15));
    if (ovr && (syn != 5'h00) && !ue) cw[syn] = ~cw[syn];
    for (int p = 1; p < 22; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = cw[p];
        j++;
      end
    end
    return {ue, ovr & ~ue, d};
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [CW_W-1:0] mem [MEM_WORDS];
  logic [9:0]  ctrl_reg;
  logic [11:0] id_reg;
  logic [23:0] lower_reg;
  logic [23:0] upper_reg;
  logic [7:0]  base_reg;
  logic [7:0]  ce_cnt_reg;
  logic [7:0]  ref_row_reg;
  logic [7:0]  ref_cnt_reg;
  logic        ref_pend_reg;
  logic        lock_hold_reg;
  logic        last_gbl_reg;
  logic        gbusy_reg;
  logic        pbusy_reg;
  logic        dbusy_reg;
  logic        pact_reg;
  logic        perr_lat_reg;
  logic        wr_lat_reg;
  logic [3:0]  hcnt_reg;
  logic [3:0]  pcnt_reg;
  logic [3:0]  ptgt_reg;
  logic [15:0] wd_lat_reg;
  state_t      state_reg;
  owner_t      owner_reg;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  logic [1:0]  ilv;
  logic [1:0]  wid;
  logic [2:0]  bank_pos;
  logic        crit;
  logic        wpar_en;
  logic        io_only;
  logic [4:0]  bank_id;
  assign ilv = ctrl_reg[CTRL_ILV_LSB +: 2];
  assign wid = ctrl_reg[CTRL_WID_LSB +: 2];
  assign bank_pos = ctrl_reg[CTRL_POS_LSB +: 3];
  assign crit = ctrl_reg[CTRL_CRIT_BIT];
  assign wpar_en = ctrl_reg[CTRL_WPAR_BIT];
  assign io_only = ctrl_reg[CTRL_IO_BIT];
  assign bank_id = id_reg[4:0];

  // ---------------------------------------------------------------
  // Port address path
  // ---------------------------------------------------------------

  // A source as wide as the interleave reaches every bank at once; a
  // narrower one uses (ilv - wid) low bits to pick a group of banks.
  logic        narrow;
  logic [1:0]  sel_n;
  logic [2:0]  sel_mask;
  logic [2:0]  pos_hi;
  logic        bank_ok;
  logic [23:0] shifted;
  logic        in_range;
  logic [23:0] port_local;
  logic        wpar_bad;
  assign narrow = wid < ilv;
  assign sel_n = narrow ? 2'(ilv - wid) : 2'h0;
  assign sel_mask = 3'((4'h1 << sel_n) - 4'h1);
  assign pos_hi = bank_pos >> wid;
  assign bank_ok = (src_addr[2:0] & sel_mask) == (pos_hi & sel_mask);
  assign shifted = src_addr >> sel_n;
  assign in_range = (shifted >= lower_reg) && (shifted <= upper_reg);
  assign port_local = shifted - lower_reg
                    + {base_reg, 16'h0000};
  assign wpar_bad = wpar_en & ~^{src_wdata, src_wpar};

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------

  // Global and local requests alternate; the port sits nearer than DMA.
  logic busy;
  logic can;
  logic gbl_ok;
  logic io_go;
  logic port_ok;
  logic dma_ok;
  logic loc_any;
  logic ref_go;
  logic g_gbl;
  logic g_port;
  logic g_dma;
  logic grant;
  assign busy = (state_reg == ST_BUSY);
  assign gbl_ok = gbl_req & (gbl_bank == bank_id) & ~gbusy_reg & ~io_only;
  assign io_go = gbl_req & (gbl_bank == bank_id) & ~gbusy_reg & io_only;
  assign port_ok = src_req & bank_ok & in_range & ~pbusy_reg;
  assign dma_ok = dma_req & ~dbusy_reg;
  assign loc_any = port_ok | dma_ok;
  assign ref_go = ~busy & ref_pend_reg & ~lock_hold_reg;
  assign can = ~busy & ~ref_go;
  assign g_gbl = can & gbl_ok & ~lock_hold_reg
               & (~loc_any | ~last_gbl_reg);
  assign g_port = can & port_ok & ~g_gbl;
  assign g_dma = can & dma_ok & ~port_ok & ~g_gbl
               & ~lock_hold_reg;
  assign grant = ref_go | g_gbl | g_port | g_dma;

  // Selected access; DMA only ever sees the local array.
  logic [23:0] g_ad;
  logic [15:0] g_wd;
  logic        g_wr;
  logic [17:0] dec;
  assign g_ad = g_port ? port_local :
                g_dma  ? {16'h0000, dma_addr} : gbl_addr;
  assign g_wd = g_port ? src_wdata : g_dma ? dma_wdata : gbl_wdata;
  assign g_wr = g_port ? src_write : g_dma ? dma_write : gbl_write;
  assign dec = ecc_dec(mem[g_ad[7:0]]);

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------

  // One wait state: pready rises in the second access cycle.
  logic        apb_acc;
  logic        apb_wr;
  logic        mapped;
  logic        id_bad;
  logic [31:0] rd_word;
  logic [31:0] stat_word;
  assign apb_acc = psel & penable;
  assign apb_wr = apb_acc & pwrite & pready & ~pslverr;
  assign id_bad = pwrite && (paddr == ID_OFF)
               && (pwdata[ID_SLOT_LSB +: 4] >= MAX_PER_DRIVER);
  assign mapped = (paddr <= AREG_OFF) && (paddr[1:0] == 2'h0);
  assign stat_word = {8'h00, ref_row_reg, ce_cnt_reg, 4'h0,
                      ref_pend_reg, lock_hold_reg, busy, pfail};
  assign rd_word = (paddr == CTRL_OFF)  ? {22'h00_0000, ctrl_reg} :
                   (paddr == ID_OFF)    ? {20'h0_0000, id_reg} :
                   (paddr == LOWER_OFF) ? {8'h00, lower_reg} :
                   (paddr == UPPER_OFF) ? {8'h00, upper_reg} :
                   (paddr == BASE_OFF)  ? {24'h00_0000, base_reg} :
                   (paddr == STAT_OFF)  ? stat_word :
                   (paddr == AREG_OFF)  ? {16'h0000, io_data} : 32'h0000_0000;

  // Answer flops; read data is frozen in the cycle pready shows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & (~mapped | id_bad);
      if (apb_acc & ~pready) prdata <= rd_word;
    end
  end

  // Switch settings held as software registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      id_reg <= ID_RST;
      lower_reg <= LOWER_RST;
      upper_reg <= UPPER_RST;
      base_reg <= BASE_RST;
    end else if (apb_wr) begin
      if (paddr == CTRL_OFF) ctrl_reg <= pwdata[9:0];
      if (paddr == ID_OFF) id_reg <= pwdata[11:0];
      if (paddr == LOWER_OFF) lower_reg <= pwdata[23:0];
      if (paddr == UPPER_OFF) upper_reg <= pwdata[23:0];
      if (paddr == BASE_OFF) base_reg <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Supply failure report
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_level <= LVL_NONCRIT;
    end else begin
      irq_req <= pfail;
      irq_level <= crit ? LVL_CRIT : LVL_NONCRIT;
    end
  end

  // ---------------------------------------------------------------
  // Refresh
  // ---------------------------------------------------------------

  // The master commands refresh; the local timer only covers the time
  // when the master has lost power. A new request wins over the clear.
  logic ref_tick;
  assign ref_tick = (ref_cnt_reg == REF_CYC - 8'h01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg <= 8'h00;
      ref_pend_reg <= 1'b0;
      ref_row_reg <= 8'h00;
    end else begin
      ref_cnt_reg <= ref_tick ? 8'h00 : ref_cnt_reg + 8'h01;
      ref_pend_reg <= gbl_refresh
                    | (ref_tick & ~master_pwr_ok)
                    | (ref_pend_reg & ~ref_go);
      if (ref_go) ref_row_reg <= ref_row_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Bus occupancy and memory cycle
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      owner_reg <= OWN_NONE;
      hcnt_reg <= 4'h0;
      last_gbl_reg <= 1'b0;
      lock_hold_reg <= 1'b0;
    end else if (!busy) begin
      if (grant) begin
        state_reg <= ST_BUSY;
        hcnt_reg <= 4'h1;
        owner_reg <= ref_go ? OWN_REF : g_gbl ? OWN_GBL :
                     g_port ? OWN_PORT : OWN_DMA;
      end
      if (g_gbl | g_port | g_dma) last_gbl_reg <= g_gbl;
      if (g_port) lock_hold_reg <= src_lock & ~lock_hold_reg;
    end else if (hcnt_reg == HOLD_CYC) begin
      state_reg <= ST_IDLE;
      owner_reg <= OWN_NONE;
    end else begin
      hcnt_reg <= hcnt_reg + 4'h1;
    end
  end

  // Storage array; a write failing its parity check is not stored.
  always_ff @(posedge pclk) begin
    if ((g_gbl | g_dma | g_port) & g_wr & ~(g_port & wpar_bad)) begin
      mem[g_ad[7:0]] <= ecc_enc(g_wd);
    end
  end

  // Read data, parity and corrected-error count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rdata <= 16'h0000;
      src_rpar <= 1'b1;
      ce_cnt_reg <= 8'h00;
      perr_lat_reg <= 1'b0;
      wr_lat_reg <= 1'b0;
      wd_lat_reg <= 16'h0000;
    end else if (g_gbl | g_port | g_dma) begin
      wr_lat_reg <= g_wr;
      wd_lat_reg <= g_wd;
      perr_lat_reg <= g_wr ? wpar_bad : dec[17];
      if (!g_wr) begin
        mem_rdata <= dec[15:0];
        src_rpar <= ~^dec[15:0];
        if (dec[16]) ce_cnt_reg <= ce_cnt_reg + 8'h01;
      end
    end
  end

  // Address, then data, on the one shared path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bp_ad <= 24'h00_0000;
      bp_data_phase <= 1'b0;
    end else if (!busy & grant) begin
      bp_ad <= ref_go ? {16'h0000, ref_row_reg} : g_ad;
      bp_data_phase <= 1'b0;
    end else if (busy & (hcnt_reg == 4'h1) & (owner_reg != OWN_REF)) begin
      bp_ad <= {8'h00, wr_lat_reg ? wd_lat_reg : mem_rdata};
      bp_data_phase <= 1'b1;
    end else if (!busy) begin
      bp_ad <= 24'h00_0000;
      bp_data_phase <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Answers to the requesters
  // ---------------------------------------------------------------

  // Port timing runs from the grant, apart from the bus hold, so a
  // read answers after the bus is already free for the next owner.
  logic hold_end;
  assign hold_end = busy & (hcnt_reg == HOLD_CYC);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pact_reg <= 1'b0;
      pcnt_reg <= 4'h0;
      ptgt_reg <= RD_CYC;
      src_done <= 1'b0;
      src_perr <= 1'b0;
    end else begin
      src_done <= pact_reg & (pcnt_reg == ptgt_reg);
      src_perr <= pact_reg & (pcnt_reg == ptgt_reg) & perr_lat_reg;
      if (g_port) begin
        pact_reg <= 1'b1;
        pcnt_reg <= 4'h1;
        ptgt_reg <= src_write ? WR_CYC : RD_CYC;
      end else if (pact_reg) begin
        pact_reg <= pcnt_reg != ptgt_reg;
        pcnt_reg <= pcnt_reg + 4'h1;
      end
    end
  end

  // Busy flags stay up through the cycle of each done pulse so that a held
  // request is not taken twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gbusy_reg <= 1'b0;
      pbusy_reg <= 1'b0;
      dbusy_reg <= 1'b0;
    end else begin
      gbusy_reg <= (gbusy_reg & ~gbl_done) | g_gbl | io_go;
      pbusy_reg <= (pbusy_reg & ~src_done) | g_port;
      dbusy_reg <= (dbusy_reg & ~dma_done) | g_dma;
    end
  end

  // Master bus answers; an I/O-only bank moves data via the A register.
  logic gdone_next;
  assign gdone_next = (hold_end & (owner_reg == OWN_GBL)) | io_go;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gbl_done <= 1'b0;
      mbus_done_p <= 1'b0;
      mbus_done_n <= 1'b1;
      dma_done <= 1'b0;
      io_data <= 16'h0000;
    end else begin
      gbl_done <= gdone_next;
      mbus_done_p <= gdone_next;
      mbus_done_n <= ~gdone_next;
      dma_done <= hold_end & (owner_reg == OWN_DMA);
      if (io_go) io_data <= gbl_write ? gbl_wdata : lbus_din;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold;
    busy [*5] ##1 !busy;
  endsequence

  crit_level_a: assert property (pfail && crit |=> irq_req && irq_level == LVL_CRIT) else $error("critical fail level");
  noncrit_level_a: assert property (pfail && !crit |=> irq_level == LVL_NONCRIT) else $error("noncritical fail level");
  bus_hold_a: assert property ($rose(busy) |-> s_hold) else $error("bus hold not 5 cycles");
  port_read_a: assert property (g_port && !src_write |-> ##7 src_done) else $error("port read late");
  port_write_a: assert property (g_port && src_write |-> !src_done [*5] ##1 src_done) else $error("port write timing");
  lock_pair_a: assert property (lock_hold_reg |-> !(g_gbl || g_dma || ref_go)) else $error("lock pair broken");
  rotate_pri_a: assert property (can && gbl_ok && port_ok && !lock_hold_reg |-> g_gbl == !last_gbl_reg) else $error("rotation wrong");
  range_gate_a: assert property (g_port |-> in_range && bank_ok) else $error("port out of range");
  wpar_report_a: assert property (g_port && src_write && wpar_bad |-> ##5 src_perr) else $error("write parity lost");
  diff_pair_a: assert property (mbus_done_p != mbus_done_n) else $error("pair not complementary");
  slot_limit_a: assert property (id_reg[11:8] < MAX_PER_DRIVER) else $error("slot over limit");

endmodule

// *** pkg/multiport_bank_pkg.sv ***
package multiport_bank_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int HOLD_NS = 500;
  localparam int RD_NS = 550;
  localparam int WR_NS = 320;
  localparam int REF_NS = 15000;
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_CYC = 4'((RD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WR_CYC = 4'((WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] REF_CYC = 8'((REF_NS + CLK_NS - 1) / CLK_NS);

  // ---------------------------------------------------------------
  // Widths and limits
  // ---------------------------------------------------------------
  localparam int AD_W = 24;
  localparam int DW = 16;
  localparam int ECC_W = 6;
  localparam int CW_W = DW + ECC_W;
  localparam int MEM_WORDS = 256;
  localparam int BASE_SHIFT = 16;
  localparam logic [3:0] MAX_PER_DRIVER = 4'h9;
  localparam logic [3:0] LVL_CRIT = 4'he;
  localparam logic [3:0] LVL_NONCRIT = 4'hd;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ID_OFF = 8'h04;
  localparam logic [7:0] LOWER_OFF = 8'h08;
  localparam logic [7:0] UPPER_OFF = 8'h0c;
  localparam logic [7:0] BASE_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] AREG_OFF = 8'h18;
  localparam int CTRL_ILV_LSB = 0;
  localparam int CTRL_WID_LSB = 2;
  localparam int CTRL_POS_LSB = 4;
  localparam int CTRL_CRIT_BIT = 7;
  localparam int CTRL_WPAR_BIT = 8;
  localparam int CTRL_IO_BIT = 9;
  localparam int ID_SLOT_LSB = 8;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [11:0] ID_RST = 12'h000;
  localparam logic [23:0] LOWER_RST = 24'h00_0000;
  localparam logic [23:0] UPPER_RST = 24'hff_ffff;
  localparam logic [7:0] BASE_RST = 8'h00;

  typedef enum logic {ST_IDLE, ST_BUSY} state_t;
  typedef enum logic [2:0] {
    OWN_NONE, OWN_GBL, OWN_PORT, OWN_DMA, OWN_REF
  } owner_t;

endpackage

// *** bench/port_source.sv ***
`timescale 1ns/1ps

// -------------------------------------------------------------
// Requesting source on the port side
// -------------------------------------------------------------
// It holds each request until the port answers, then drops it.
// Released address and data lines show the inverse, so a stale value never passes.
module port_source (
  // Clock, reset and command from the bench.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic        lk,
  input  wire logic        bad,
  input  wire logic [23:0] sa,
  input  wire logic [15:0] sd,
  // Port request lines.
  input  wire logic        src_done,
  output logic             src_req,
  output logic             src_write,
  output logic             src_lock,
  output logic [23:0]      src_addr,
  output logic [15:0]      src_wdata,
  output logic             src_wpar
);
  // Only one request is open at a time, as the port expects.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_req   <= 1'b0;
      src_write <= 1'b0;
      src_lock  <= 1'b0;
      src_addr  <= 24'h00_0000;
      src_wdata <= 16'h0000;
      src_wpar  <= 1'b0;
    end else if (src_req && src_done) begin
      src_req   <= 1'b0;
      src_lock  <= 1'b0;
      src_addr  <= ~src_addr;
      src_wdata <= ~src_wdata;
    end else if (go && !src_req) begin
      src_req   <= 1'b1;
      src_write <= wr;
      src_lock  <= lk;
      src_addr  <= sa;
      src_wdata <= sd;
      src_wpar  <= ~^sd ^ bad;
    end
  end
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end

// -------------------------------------------------------------
// Bench top
// -------------------------------------------------------------
module tb;
  import multiport_bank_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pfail = 0, go = 0, wr = 0, lk = 0, bad = 0;
  logic [7:0]  paddr = 8'h00;
  logic        gbl_req = 0, gbl_write = 0, gbl_refresh = 0, dma_req = 0;
  logic        gbl_done, mbus_done_p, mbus_done_n, dma_done;
  logic [23:0] gbl_addr = 24'h00_0000;
  logic [15:0] gbl_wdata = 16'h0000;
  logic [7:0]  dma_addr = 8'h00;
  logic [17:0] m_q[$], em;
  logic [32:0] ea;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [23:0] sa = 24'h00_0000, src_addr, bp_ad;
  logic [15:0] sd = 16'h0000, src_wdata, mem_rdata, io_data;
  logic        pready, pslverr, irq_req, src_req, src_write, src_lock;
  logic        src_wpar, src_done, src_perr, src_rpar, bp_data_phase;
  logic [3:0]  irq_level, wait_cnt = 4'h0;
  logic [32:0] apb_q[$];
  logic [21:0] src_q[$], e;
  logic [15:0] d[4];
  logic [7:0]  a[4];
  int          error_cnt = 0, n_tests = 0;

  // Bank 0 with the master alive; local DMA only ever reads.
  multiport_bank_access u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pfail, .irq_req, .irq_level, .gbl_req,
    .gbl_write, .gbl_bank(5'h00), .gbl_addr, .gbl_wdata, .gbl_refresh,
    .master_pwr_ok(1'b1), .lbus_din(16'h0000), .gbl_done, .mbus_done_p,
    .mbus_done_n, .mem_rdata, .io_data, .src_req, .src_write, .src_lock,
    .src_addr, .src_wdata, .src_wpar, .src_done, .src_perr, .src_rpar,
    .dma_req, .dma_write(1'b0), .dma_addr, .dma_wdata(16'h0000), .dma_done,
    .bp_ad, .bp_data_phase);

  port_source u_src (.pclk, .presetn, .go, .wr, .lk, .bad, .sa, .sd,
    .src_done, .src_req, .src_write, .src_lock, .src_addr, .src_wdata,
    .src_wpar);

  // Clock: 100 ns period.
  always #50 pclk = ~pclk;

  // APB transfer; a read notes {pslverr, prdata} it expects first.
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd, input logic [32:0] ex);
    if (!w) apb_q.push_back(ex);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Port access; the note is {latency, read, parity error, data}.
  task automatic port(input logic w, l, b, input logic [23:0] ad,
                      input logic [15:0] wd, input logic [15:0] ex,
                      input logic pe);
    src_q.push_back({w ? WR_CYC + 4'h1 : RD_CYC + 4'h1, !w, pe, ex});
    wr  <= w;
    lk  <= l;
    bad <= b;
    sa  <= ad;
    sd  <= wd;
    go  <= 1'b1;
    @(posedge pclk) go <= 1'b0;
    do @(posedge pclk); while (src_done !== 1'b1);
    @(posedge pclk);
  endtask

  // Master bus or DMA request; the note is {dma, write, bus data}.
  task automatic mreq(input logic dm, w, input logic [7:0] ad,
                      input logic [15:0] wd, ex);
    m_q.push_back({dm, w, ex});
    gbl_req   <= ~dm;
    dma_req   <= dm;
    gbl_write <= w;
    gbl_addr  <= {16'h0000, ad};
    gbl_wdata <= wd;
    dma_addr  <= ad;
    do @(posedge pclk); while (gbl_done !== 1'b1 && dma_done !== 1'b1);
    gbl_req <= 1'b0;
    dma_req <= 1'b0;
    @(posedge pclk);
  endtask

  // Result watcher: the oldest note is matched to each answer.
  // Notes are popped into a variable so a mismatch report reads it once.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && apb_q.size() > 0) begin
      ea = apb_q.pop_front();
      `CHK("apb read", ea, {pslverr, prdata})
    end
    if (src_done === 1'b1) begin
      e = src_q.pop_front();
      `CHK("port", e, {wait_cnt, e[17], src_perr,
                       e[17] ? mem_rdata : 16'h0000})
      if (e[17])
        `CHK("read parity", 1'b1, ^{mem_rdata, src_rpar})
    end
    if (gbl_done === 1'b1 || dma_done === 1'b1) begin
      em = m_q.pop_front();
      `CHK("done source", em[17], dma_done)
      `CHK("pair", {~em[17], em[17]},
           {mbus_done_p, mbus_done_n})
      if (!em[16]) `CHK("bus read", em[15:0], mem_rdata)
    end
    if (bp_data_phase === 1'b1 && m_q.size() > 0)
      `CHK("bus data", {8'h00, m_q[0][15:0]}, bp_ad)
    wait_cnt <= src_req ? wait_cnt + 4'h1 : 4'h0;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 2000 cycles.
  initial begin
    #(CLK_NS * 5000);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'hf936_a15b));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, UPPER_OFF, 32'h0, 33'h0_00ff_ffff);
    apb(1'b0, CTRL_OFF, 32'h0, 33'h0_0000_0000);
    apb(1'b0, 8'h1c, 32'h0, 33'h1_0000_0000);
    pfail <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("irq level", {1'b1, LVL_NONCRIT}, {irq_req, irq_level})
    // Critical bank with write parity checking switched on.
    apb(1'b1, CTRL_OFF, 32'h0000_0180, 33'h0);
    repeat (2) @(posedge pclk);
    `CHK("irq level", {1'b1, LVL_CRIT}, {irq_req, irq_level})
    pfail <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      a[i] = 8'(i * 8'h11 + ($urandom % 8'h10));
      d[i] = 16'($urandom);
      port(1'b1, 1'b0, 1'b0, {16'h0000, a[i]}, d[i], 16'h0000, 1'b0);
      port(1'b0, i == 0, 1'b0, {16'h0000, a[i]}, 16'h0000, d[i], 1'b0);
    end
    // A bad-parity write is flagged and must not reach the memory.
    port(1'b1, 1'b0, 1'b1, {16'h0000, a[1]}, ~d[1], 16'h0000, 1'b1);
    port(1'b0, 1'b0, 1'b0, {16'h0000, a[1]}, 16'h0000, d[1], 1'b0);
    // A raised lower limit moves the window by the same amount.
    apb(1'b1, LOWER_OFF, 32'h0000_0010, 33'h0);
    port(1'b0, 1'b0, 1'b0, {16'h0000, a[2]} + 24'h00_0010, 16'h0000,
         d[2], 1'b0);
    // Master bus writes, local DMA reads it back, master bus reads.
    mreq(1'b0, 1'b1, a[0], d[3], d[3]);
    mreq(1'b1, 1'b0, a[0], 16'h0000, d[3]);
    mreq(1'b0, 1'b0, a[2], 16'h0000, d[2]);
    // A refresh command takes one bus slot and advances the row.
    gbl_refresh <= 1'b1;
    @(posedge pclk) gbl_refresh <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1'b0, STAT_OFF, 32'h0, 33'h0_0001_0000);
    // A slot number past the limit is refused and not stored.
    apb(1'b1, ID_OFF, 32'h0000_0900, 33'h0);
    apb(1'b0, ID_OFF, 32'h0, 33'h0_0000_0000);
    // An I/O-only bank hands master data to the A register.
    apb(1'b1, CTRL_OFF, 32'h0000_0380, 33'h0);
    mreq(1'b0, 1'b1, 8'h00, d[0], d[0]);
    apb(1'b0, AREG_OFF, 32'h0, {17'h0_0000, d[0]});
    tally_and_finish();
  end
endmodule
